/* src/drtc_top.sv */
// Purpose: Two 8-bit reload timer/counters with shared prescaler
// Assumes: All inputs synchronous to sys_clk_i; reads answer one cycle later
// Notes:   Interrupt enables come from the interrupt controller outside
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module drtc_top
    import drtc_pkg::*;
#(
    parameter int PRESC_LOG2 = 1
) (
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    input  wire logic              ptr_lsb_i,
    output logic      [DATA_W-1:0] rdata_o,
    // External event
    input  wire logic              event_count_i,
    // Interrupt controller side
    input  wire logic              t1_irq_en_i,
    input  wire logic              t2_irq_en_i,
    output logic                   t1_irq_req_o,
    output logic                   t2_irq_req_o
);

    if (PRESC_LOG2 < PRESC_LOG2_MIN || PRESC_LOG2 > PRESC_LOG2_MAX) begin : g_chk
        $error("PRESC_LOG2 must lie between 1 and 12");
    end

    function automatic logic [CNT_W-1:0] set_nib(input logic [CNT_W-1:0] old,
                                                 input logic hi,
                                                 input logic [DATA_W-1:0] nib);
        logic [CNT_W-1:0] r;
        r = old;
        if (hi) begin
            r[7:4] = nib;
        end else begin
            r[3:0] = nib;
        end
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] get_nib(input logic [CNT_W-1:0] v,
                                                  input logic hi);
        return hi ? v[7:4] : v[3:0];
    endfunction

    // Overflow: a counting tick while the count stands at its maximum
    function automatic logic tmr_ovf(input drtc_tmr_t cur, input logic tick);
        return cur.run && tick && (cur.cnt == CNT_MAX);
    endfunction

    // Next count: a start loads the initial value, overflow reloads or clears
    function automatic logic [CNT_W-1:0] tmr_next_cnt(input drtc_tmr_t        cur,
                                                      input logic             tick,
                                                      input logic             rep,
                                                      input logic [CNT_W-1:0] ival,
                                                      input logic             start);
        logic [CNT_W-1:0] n;
        n = cur.cnt;
        if (start) begin
            n = ival;
        end else if (tmr_ovf(cur, tick)) begin
            n = rep ? ival : CNT_RST;
        end else if (cur.run && tick) begin
            n = cur.cnt + 8'h01;
        end
        return n;
    endfunction

    // Next run state: single mode stops at overflow until the next start
    function automatic logic tmr_next_run(input drtc_tmr_t cur,
                                          input logic      tick,
                                          input logic      rep,
                                          input logic      start);
        logic r;
        r = cur.run;
        if (start) begin
            r = 1'b1;
        end else if (tmr_ovf(cur, tick)) begin
            r = rep;
        end
        return r;
    endfunction

    // Next flag: a start clears it, an enabled overflow sets it, and the set wins
    function automatic logic tmr_next_flag(input drtc_tmr_t cur,
                                           input logic      tick,
                                           input logic      start,
                                           input logic      irq_en);
        logic f;
        f = cur.ovf_flag;
        if (start) begin
            f = 1'b0;
        end
        if (tmr_ovf(cur, tick) && irq_en) begin
            f = 1'b1;
        end
        return f;
    endfunction

    // Whole next state of one timer
    function automatic drtc_tmr_t tmr_step(input drtc_tmr_t        cur,
                                           input logic             tick,
                                           input logic             rep,
                                           input logic [CNT_W-1:0] ival,
                                           input logic             start,
                                           input logic             irq_en);
        drtc_tmr_t nx;
        nx.cnt      = tmr_next_cnt(cur, tick, rep, ival, start);
        nx.run      = tmr_next_run(cur, tick, rep, start);
        nx.ovf_flag = tmr_next_flag(cur, tick, start, irq_en);
        return nx;
    endfunction

    // True when a strobe hits the given register offset
    function automatic logic reg_hit(input logic              strobe,
                                     input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] ofs);
        return strobe && (addr == ofs);
    endfunction

    // Control readback; timer one has no clock mask, so its bit 3 reads 0
    function automatic logic [DATA_W-1:0] ctrl_word(input drtc_cfg_t cfg,
                                                    input logic      flag,
                                                    input logic      has_mask);
        logic [DATA_W-1:0] w;
        w                = '0;
        w[T2_MASK_BIT]   = has_mask && cfg.clk_mask;
        w[T1_PSTOP_BIT]  = cfg.bit2;
        w[CTRL_MODE_BIT] = cfg.repeat_mode;
        w[CTRL_FLAG_BIT] = flag;
        return w;
    endfunction

    // Control write; bit 2 is the prescaler stop on timer one, the source on timer two
    function automatic drtc_cfg_t cfg_write(input drtc_cfg_t         cfg,
                                            input logic [DATA_W-1:0] nib,
                                            input logic              has_mask);
        drtc_cfg_t c;
        c             = cfg;
        c.repeat_mode = nib[CTRL_MODE_BIT];
        c.bit2        = has_mask ? nib[T2_EXTSEL_BIT] : nib[T1_PSTOP_BIT];
        if (has_mask) begin
            c.clk_mask = nib[T2_MASK_BIT];
        end
        return c;
    endfunction

    // Configuration group
    drtc_cfg_t         cfg1_q;
    drtc_cfg_t         cfg1_d;
    drtc_cfg_t         cfg2_q;
    drtc_cfg_t         cfg2_d;
    logic [CNT_W-1:0]  ival1_q;
    logic [CNT_W-1:0]  ival1_d;
    logic [CNT_W-1:0]  ival2_q;
    logic [CNT_W-1:0]  ival2_d;

    // Read group
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] ctrl1_word;
    logic [DATA_W-1:0] ctrl2_word;

    // Strobe decode
    logic              wr_t1_ctrl;
    logic              wr_t1_ival;
    logic              wr_t2_ctrl;
    logic              wr_t2_ival;
    logic              rd_t1_ctrl;
    logic              rd_t1_ival;
    logic              rd_t2_ctrl;
    logic              rd_t2_ival;
    logic              start1;
    logic              start2;

    // Prescaler group
    logic [2:0]         instr_div_q;
    logic [2:0]         instr_div_d;
    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] presc_d;
    logic               evt_prev_q;
    logic               evt_prev_d;
    logic               presc_halt;
    logic               instr_tick;
    logic               int_tick;
    logic               ext_tick;
    logic               t1_tick;
    logic               t2_tick;

    // Timer one group
    drtc_tmr_t tmr1_q;
    drtc_tmr_t tmr1_d;
    logic      ovf1;
    logic      irq1_q;
    logic      irq1_d;

    // Timer two group
    drtc_tmr_t tmr2_q;
    drtc_tmr_t tmr2_d;
    logic      ovf2;
    logic      irq2_q;
    logic      irq2_d;

    assign rdata_o      = rdata_q;
    assign t1_irq_req_o = irq1_q;
    assign t2_irq_req_o = irq2_q;

    // Write strobes
    assign wr_t1_ctrl = reg_hit(wr_i, addr_i, OFS_T1_CTRL);
    assign wr_t1_ival = reg_hit(wr_i, addr_i, OFS_T1_IVAL);
    assign wr_t2_ctrl = reg_hit(wr_i, addr_i, OFS_T2_CTRL);
    assign wr_t2_ival = reg_hit(wr_i, addr_i, OFS_T2_IVAL);
    // Read strobes
    assign rd_t1_ctrl = reg_hit(rd_i, addr_i, OFS_T1_CTRL);
    assign rd_t1_ival = reg_hit(rd_i, addr_i, OFS_T1_IVAL);
    assign rd_t2_ctrl = reg_hit(rd_i, addr_i, OFS_T2_CTRL);
    assign rd_t2_ival = reg_hit(rd_i, addr_i, OFS_T2_IVAL);
    assign start1     = wr_t1_ctrl && wdata_i[CTRL_START_BIT];
    assign start2     = wr_t2_ctrl && wdata_i[CTRL_START_BIT];

    // Control and initial value writes; the start bit is a pulse, not stored
    always_comb begin
        cfg1_d  = cfg1_q;
        cfg2_d  = cfg2_q;
        ival1_d = ival1_q;
        ival2_d = ival2_q;
        if (wr_t1_ctrl) begin
            cfg1_d = cfg_write(cfg1_q, wdata_i, 1'b0);
        end
        if (wr_t2_ctrl) begin
            cfg2_d = cfg_write(cfg2_q, wdata_i, 1'b1);
        end
        if (wr_t1_ival) begin
            ival1_d = set_nib(ival1_q, ptr_lsb_i, wdata_i);
        end
        if (wr_t2_ival) begin
            ival2_d = set_nib(ival2_q, ptr_lsb_i, wdata_i);
        end
    end

    // All configuration clears on reset, so timer two starts masked
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cfg1_q.clk_mask    <= CFG_BIT_RST;
            cfg1_q.bit2        <= CFG_BIT_RST;
            cfg1_q.repeat_mode <= CFG_BIT_RST;
            cfg2_q.clk_mask    <= CFG_BIT_RST;
            cfg2_q.bit2        <= CFG_BIT_RST;
            cfg2_q.repeat_mode <= CFG_BIT_RST;
            ival1_q            <= IVAL_RST;
            ival2_q            <= IVAL_RST;
        end else begin
            cfg1_q             <= cfg1_d;
            cfg2_q             <= cfg2_d;
            ival1_q            <= ival1_d;
            ival2_q            <= ival2_d;
        end
    end

    assign ctrl1_word = ctrl_word(cfg1_q, tmr1_q.ovf_flag, 1'b0);
    assign ctrl2_word = ctrl_word(cfg2_q, tmr2_q.ovf_flag, 1'b1);

    // Count reads give the live count, one nibble per pointer bit
    always_comb begin
        rdata_d = '0;
        if (rd_t1_ctrl) begin
            rdata_d = ctrl1_word;
        end
        if (rd_t2_ctrl) begin
            rdata_d = ctrl2_word;
        end
        if (rd_t1_ival) begin
            rdata_d = get_nib(tmr1_q.cnt, ptr_lsb_i);
        end
        if (rd_t2_ival) begin
            rdata_d = get_nib(tmr2_q.cnt, ptr_lsb_i);
        end
    end

    // Read data stand for the one cycle after the strobe, then return to zero
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Internal tick: one instruction cycle every six clocks, then divided by 2^PRESC_LOG2
    assign presc_halt = cfg1_q.bit2;
    assign instr_tick = !presc_halt && (instr_div_q == INSTR_CLKS - 3'h1);
    assign int_tick   = instr_tick && (&presc_q[PRESC_LOG2-1:0]);
    assign ext_tick   = event_count_i && !evt_prev_q;
    assign t1_tick    = int_tick;
    assign t2_tick    = cfg2_q.clk_mask && (cfg2_q.bit2 ? ext_tick : int_tick);

    always_comb begin
        evt_prev_d  = event_count_i;
        instr_div_d = instr_div_q;
        presc_d     = presc_q;
        if (presc_halt) begin
            // Held at zero while halted, so a restart divides from zero
            instr_div_d = '0;
            presc_d     = '0;
        end else if (instr_tick) begin
            instr_div_d = '0;
            presc_d     = presc_q + 12'h001;
        end else begin
            instr_div_d = instr_div_q + 3'h1;
        end
    end

    // Event history starts low, the idle level of its pin
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            instr_div_q <= '0;
            presc_q     <= '0;
            evt_prev_q  <= 1'b0;
        end else begin
            instr_div_q <= instr_div_d;
            presc_q     <= presc_d;
            evt_prev_q  <= evt_prev_d;
        end
    end

    // Without a tick or a start the counter simply holds its value
    always_comb begin
        ovf1   = tmr_ovf(tmr1_q, t1_tick);
        tmr1_d = tmr_step(tmr1_q,
                          t1_tick,
                          cfg1_q.repeat_mode,
                          ival1_q,
                          start1,
                          t1_irq_en_i);
        irq1_d = ovf1 && t1_irq_en_i;
    end

    // Request is a one-cycle pulse to the interrupt controller
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tmr1_q.cnt      <= CNT_RST;
            tmr1_q.run      <= 1'b0;
            tmr1_q.ovf_flag <= 1'b0;
            irq1_q          <= 1'b0;
        end else begin
            tmr1_q          <= tmr1_d;
            irq1_q          <= irq1_d;
        end
    end

    // Timer two runs the same step on its own tick
    always_comb begin
        ovf2   = tmr_ovf(tmr2_q, t2_tick);
        tmr2_d = tmr_step(tmr2_q,
                          t2_tick,
                          cfg2_q.repeat_mode,
                          ival2_q,
                          start2,
                          t2_irq_en_i);
        irq2_d = ovf2 && t2_irq_en_i;
    end

    // Request is a one-cycle pulse to the interrupt controller
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tmr2_q.cnt      <= CNT_RST;
            tmr2_q.run      <= 1'b0;
            tmr2_q.ovf_flag <= 1'b0;
            irq2_q          <= 1'b0;
        end else begin
            tmr2_q          <= tmr2_d;
            irq2_q          <= irq2_d;
        end
    end

endmodule

/* pkg/drtc_pkg.sv */
// Purpose: Constants and types for the dual reload timer/counter
// Assumes: Registers reached over a 4-bit nibble port at peripheral offsets
// Notes:   Nibble half selected by the pointer LSB, as for the CPU
//
// Overview of operation
// - Two timer/counters sharing one prescaler, each an 8-bit binary up-counter.
// - Timer one counts prescaler ticks; timer two picks internal or event input by bit 2.
// - Each timer has its own software-written initial value used as start count.
// - Rollover FF to 00 with interrupt enabled raises an interrupt request.
// - Repeat mode reloads the initial value on overflow and keeps counting.
// - Single mode stops the counter at overflow until software restarts it.
// - Writing 1 to control bit 0 loads the latest initial value and starts counting.
// - Overflow sets the flag only when that timer's interrupt is enabled.
// - Flag clears on a start write and on system reset.
// - Internal clock is instruction rate (six clocks) divided by a power of two.
// - Timer-one control bit 2 at 1 halts the prescaler and internal counting.
// - Halted counters keep their value and resume from it.
// - Prescaler divider restarts from zero after a halt.
// - Timer-two bit 3 at 0 holds the count; at 1 counting resumes.
// - Initial value writes update one nibble chosen by the pointer LSB.
// - Reads at the initial value address return the live count.
// - Count reads return one nibble per pointer LSB; live reads may mix counts.
package drtc_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 4;
    localparam int CNT_W  = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_T1_CTRL = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_T1_IVAL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_T2_CTRL = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_T2_IVAL = 4'h6;

    // Control field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_FLAG_BIT  = 0;
    localparam int CTRL_MODE_BIT  = 1;
    localparam int T1_PSTOP_BIT   = 2;
    localparam int T2_EXTSEL_BIT  = 2;
    localparam int T2_MASK_BIT    = 3;

    // Reset values
    localparam logic             CFG_BIT_RST = 1'b0;
    localparam logic [CNT_W-1:0] IVAL_RST    = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST     = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MAX     = 8'hff;

    // Timing: system clocks per instruction cycle
    localparam logic [2:0] INSTR_CLKS     = 3'h6;
    localparam int         PRESC_W        = 12;
    localparam int         PRESC_LOG2_MIN = 1;
    localparam int         PRESC_LOG2_MAX = 12;

    typedef struct packed {
        logic             clk_mask;
        logic             bit2;
        logic             repeat_mode;
    } drtc_cfg_t;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             run;
        logic             ovf_flag;
    } drtc_tmr_t;

endpackage

/* bench/drtc_props.sv */
// Purpose: Port assertions for drtc_top
// Assumes: Control bits tracked from the write strobe
// Notes:   Bound to every drtc_top instance
`timescale 1ns/10ps
module drtc_props
    import drtc_pkg::*;
(
    // Watched ports
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic              t1_irq_en_i,
    input wire logic              t2_irq_en_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic              t1_irq_req_o,
    input wire logic              t2_irq_req_o
);
    logic [1:0] t1_q;
    logic [1:0] t1_d;
    logic       msk_q;
    logic       msk_d;
    always_comb begin
        t1_d = t1_q;
        msk_d = msk_q;
        if (wr_i && addr_i == OFS_T1_CTRL) t1_d = wdata_i[2:1];
        if (wr_i && addr_i == OFS_T2_CTRL) msk_d = wdata_i[3];
    end
    always_ff @(posedge sys_clk_i) begin
        t1_q <= rst_i ? 2'h0 : t1_d;
        msk_q <= rst_i ? 1'b0 : msk_d;
    end
    default clocking dc @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    chk_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 4'h0)
        else $error("read data outside read slot");
    chk_unmapped_read: assert property (rd_i && !(addr_i inside {[4'h3:4'h6]}) |=> rdata_o == 4'h0)
        else $error("unmapped read not zero");
    chk_ctrl1_readback: assert property (rd_i && addr_i == OFS_T1_CTRL |=> rdata_o[3:1] == {1'b0, $past(t1_q)})
        else $error("timer one control readback");
    chk_ctrl2_mask: assert property (rd_i && addr_i == OFS_T2_CTRL |=> rdata_o[3] == $past(msk_q))
        else $error("timer two mask readback");
    chk_irq1_pulse: assert property (t1_irq_req_o |=> !t1_irq_req_o)
        else $error("timer one request too long");
    chk_irq2_pulse: assert property (t2_irq_req_o |=> !t2_irq_req_o)
        else $error("timer two request too long");
    chk_irq1_enable: assert property (t1_irq_req_o |-> $past(t1_irq_en_i))
        else $error("timer one request while disabled");
    chk_irq2_enable: assert property (t2_irq_req_o |-> $past(t2_irq_en_i))
        else $error("timer two request while disabled");
    chk_halt_quiet: assert property (t1_q[1] && $past(t1_q[1]) |-> !t1_irq_req_o)
        else $error("timer one overflow while halted");
    chk_mask_quiet: assert property (!msk_q && !$past(msk_q) |-> !t2_irq_req_o)
        else $error("timer two overflow while masked");
    cov_irq1: cover property (t1_irq_req_o);
    cov_irq2: cover property (t2_irq_req_o);
    cov_halt: cover property (t1_q[1] ##1 !t1_q[1]);
endmodule
bind drtc_top drtc_props u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .t1_irq_en_i(t1_irq_en_i),
    .t2_irq_en_i(t2_irq_en_i), .rdata_o(rdata_o), .t1_irq_req_o(t1_irq_req_o),
    .t2_irq_req_o(t2_irq_req_o));

/* bench/drtc_bench.sv */
// Purpose: Self-checking bench for drtc_top
// Assumes: Default prescaler ratio, tick every 12 clocks
// Notes:   Counts read as two nibble reads, upper first
`timescale 1ns/10ps
module drtc_bench
    import drtc_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 4'h0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic              ptr = 1'b0;
    logic              ev = 1'b0;
    logic              en1 = 1'b1;
    logic              en2 = 1'b1;
    logic [DATA_W-1:0] rdata;
    logic              irq1;
    logic              irq2;
    logic [CNT_W-1:0]  c0;
    logic [CNT_W-1:0]  c1;
    int                n_fail = 0;
    int                tests_run = 0;
    int                cycles = 0;
    always #50 clk = ~clk;
    drtc_top dut (.sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .ptr_lsb_i(ptr), .rdata_o(rdata), .event_count_i(ev), .t1_irq_en_i(en1),
        .t2_irq_en_i(en2), .t1_irq_req_o(irq1), .t2_irq_req_o(irq2));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr4(input logic [3:0] a, input logic p, input logic [3:0] d);
        @(posedge clk);
        addr <= a;
        ptr <= p;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd4(input logic [3:0] a, input logic p, output logic [3:0] d);
        @(posedge clk);
        addr <= a;
        ptr <= p;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd8(input logic [3:0] a, output logic [7:0] c);
        rd4(a, 1'b1, c[7:4]);
        rd4(a, 1'b0, c[3:0]);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [3:0] e);
        logic [3:0] v;
        rd4(a, 1'b0, v);
        chk({4'h0, v}, {4'h0, e});
    endtask
    task automatic rdn(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] c;
        rd8(a, c);
        chk(c, e);
    endtask
    task automatic wait_irq(input logic t2);
        int k;
        k = 0;
        #1;
        while ((t2 ? irq2 : irq1) !== 1'b1 && k < 300) begin
            @(posedge clk);
            #1 k++;
        end
        chk(8'(k < 300), 8'h01);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            ev <= 1'b1;
            @(posedge clk);
            ev <= 1'b0;
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc(OFS_T1_CTRL, 4'h0);
        rdc(OFS_T2_CTRL, 4'h0);
        rdc(4'h7, 4'h0);
        wr4(OFS_T1_IVAL, 1'b1, 4'hf);
        wr4(OFS_T1_IVAL, 1'b0, 4'he);
        wr4(OFS_T1_CTRL, 1'b0, 4'h1);
        rdn(OFS_T1_IVAL, 8'hfe);
        wait_irq(1'b0);
        rdn(OFS_T1_IVAL, 8'h00);
        rdc(OFS_T1_CTRL, 4'h1);
        repeat (40) @(posedge clk);
        rdn(OFS_T1_IVAL, 8'h00);
        wr4(OFS_T1_CTRL, 1'b0, 4'h3);
        rdc(OFS_T1_CTRL, 4'h2);
        wait_irq(1'b0);
        rdn(OFS_T1_IVAL, 8'hfe);
        rdn(OFS_T2_IVAL, 8'h00);
        wr4(OFS_T1_CTRL, 1'b0, 4'h3);
        en1 <= 1'b0;
        repeat (60) @(posedge clk);
        rdc(OFS_T1_CTRL, 4'h2);
        wr4(OFS_T1_CTRL, 1'b0, 4'h6);
        rdc(OFS_T1_CTRL, 4'h6);
        rd8(OFS_T1_IVAL, c0);
        repeat (50) @(posedge clk);
        rd8(OFS_T1_IVAL, c1);
        chk(c1, c0);
        wr4(OFS_T1_CTRL, 1'b0, 4'h2);
        en1 <= 1'b1;
        wait_irq(1'b0);
        rdn(OFS_T1_IVAL, 8'hfe);
        wr4(OFS_T2_IVAL, 1'b1, 4'hf);
        wr4(OFS_T2_IVAL, 1'b0, 4'hd);
        wr4(OFS_T2_CTRL, 1'b0, 4'hf);
        rdc(OFS_T2_CTRL, 4'he);
        pulse(2);
        rdn(OFS_T2_IVAL, 8'hff);
        pulse(1);
        wait_irq(1'b1);
        rdn(OFS_T2_IVAL, 8'hfd);
        wr4(OFS_T1_CTRL, 1'b0, 4'h4);
        pulse(1);
        rdn(OFS_T2_IVAL, 8'hfe);
        wr4(OFS_T2_CTRL, 1'b0, 4'h6);
        pulse(2);
        rdn(OFS_T2_IVAL, 8'hfe);
        wr4(OFS_T2_CTRL, 1'b0, 4'he);
        pulse(1);
        rdn(OFS_T2_IVAL, 8'hff);
        wr4(OFS_T1_IVAL, 1'b1, 4'h7);
        wr4(OFS_T1_CTRL, 1'b0, 4'h1);
        rdn(OFS_T1_IVAL, 8'h7e);
        end_sim();
    end
endmodule
